//--- hw/scaler_params.svh
// constants for the hybrid subcarrier scaler
// assumes inclusion by bare name from the multiplier, scaler and bench files
`ifndef SCALER_PARAMS_SVH
`define SCALER_PARAMS_SVH
`define IDX_W      8
`define SMP_W      16
`define GAIN_W     16
`define GAIN_FRAC  15
`define PROD_W     33
`define TAB_AW     5
`define TAB_DEPTH  25
`define FIFO_DEPTH 4
`define FIFO_W     (1 + `IDX_W + 2 * `SMP_W)
`define MAX_IDX    8'h51
`define REF_IDX    8'h01
`define TER_LO     8'h02
`define TER_HI     8'h1A
`define INNER_IDX  8'h1B
`define SEC_LO     8'h1C
`define SEC_HI     8'h34
`define OUTER_IDX  8'h35
`define GAP_LO     8'h36
`define GAP_HI     8'h38
`define PRI_LO     8'h39
`define OID_A      2'h0
`define OID_B      2'h1
`endif

//--- hw/scaler_pkg.sv
// types shared by the hybrid subcarrier scaler
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package scaler_pkg;
  // sideband a subcarrier index falls in
  typedef enum logic [2:0] {SB_OFF, SB_REF, SB_TER, SB_INNER, SB_SEC, SB_OUTER, SB_PRI} sideband_t;
endpackage : scaler_pkg
`default_nettype wire

//--- hw/sample_fifo.sv
// small synchronous fifo for the subcarrier stream
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_mclk,     // clock
  input  wire logic             i_reset_n,  // sync reset, low
  input  wire logic             i_wr_valid, // write request
  output logic                  o_wr_ready, // room left, registered
  input  wire logic [WIDTH-1:0] i_wr_data,  // write word
  output logic                  o_rd_valid, // word available
  input  wire logic             i_rd_ready, // reader takes word
  output logic      [WIDTH-1:0] o_rd_data   // head word
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             wr_go;
  logic             rd_go;

  // ==========================================================
  // handshake terms
  assign wr_go = i_wr_valid && o_wr_ready;
  assign rd_go = o_rd_valid && i_rd_ready;
  assign o_rd_data = mem[rd_ptr];
  assign next_count = count + CW'(wr_go) - CW'(rd_go);

  // storage carries no reset, only pointers, count and flags do
  always_ff @(posedge i_mclk)
  begin
    if (wr_go)
      mem[wr_ptr] <= i_wr_data;
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (wr_go)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (rd_go)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
  end

  // ready and valid are flops so upstream sees no combinational path
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      count      <= '0;
      o_wr_ready <= 1'b0;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      count      <= next_count;
      o_wr_ready <= next_count != CW'(DEPTH);
      o_rd_valid <= next_count != '0;
    end
  end

  fifo_bound_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    count <= CW'(DEPTH)) else $error("fifo count above depth");
  fifo_ready_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (count == CW'(DEPTH)) |-> !o_wr_ready) else $error("fifo ready while full");
endmodule : sample_fifo
`default_nettype wire

//--- hw/subcarrier_multiplier.sv
// complex sample times unsigned gain, with conjugate and blanking
// assumes gains in unsigned fixed point with GAIN_FRAC fraction bits
`timescale 1ns/1ps
`default_nettype none
`include "scaler_params.svh"
module subcarrier_multiplier (
  input  wire logic signed [`SMP_W-1:0]  i_re,   // real in
  input  wire logic signed [`SMP_W-1:0]  i_im,   // imag in
  input  wire logic        [`GAIN_W-1:0] i_gain, // scale factor
  input  wire logic                      i_conj, // conjugate
  input  wire logic                      i_zero, // blank output
  output logic signed      [`SMP_W-1:0]  o_re,   // real out
  output logic signed      [`SMP_W-1:0]  o_im    // imag out
);
  logic signed [`PROD_W-1:0] p_re;
  logic signed [`PROD_W-1:0] p_im;

  // saturate rather than wrap: gains above unity are legal
  function automatic logic signed [`SMP_W-1:0] sat(input logic signed [`PROD_W-1:0] p);
    logic signed [`PROD_W-1:0] s;
    s = p >>> `GAIN_FRAC;
    if (s > `PROD_W'($signed({1'b0, {(`SMP_W-1){1'b1}}})))
      sat = {1'b0, {(`SMP_W-1){1'b1}}};
    else if (s < -`PROD_W'($signed({1'b0, {(`SMP_W-1){1'b1}}})) - 1)
      sat = {1'b1, {(`SMP_W-1){1'b0}}};
    else
      sat = s[`SMP_W-1:0];
  endfunction : sat

  // products in 33 bits; negation for conjugate cannot overflow here
  assign p_re = $signed({{(`PROD_W-`SMP_W){i_re[`SMP_W-1]}}, i_re})
              * $signed({{(`PROD_W-`GAIN_W){1'b0}}, i_gain});
  assign p_im = $signed({{(`PROD_W-`SMP_W){i_im[`SMP_W-1]}}, i_im})
              * $signed({{(`PROD_W-`GAIN_W){1'b0}}, i_gain});
  assign o_re = i_zero ? '0 : sat(p_re);
  assign o_im = i_zero ? '0 : sat(i_conj ? -p_im : p_im);
endmodule : subcarrier_multiplier
`default_nettype wire

//--- hw/hybrid_subcarrier_scaler.sv
// hybrid subcarrier scaler: sideband placement and per-subcarrier gain
// assumes one subcarrier per accepted word, symbol start flagged on
// its first word, and gain ports held steady by the configuration side
//
// Summary of operation
// - indices -81..81 handled, zero is centre
// - index passes through unchanged, fixing frequency
// - indices 54..56 and mirrors output zero
// - upper primary 57..81 uses one gain
// - lower primary uses its own gain
// - secondary picks gain a/b by power level
// - tertiary uses own entry of table a/b
// - reduced bandwidth zeroes secondary, tertiary, inner ident
// - reference subcarriers use the reference gain
// - inner ident by power level, -27 conjugated
// - index 53 gets upper primary times ident
// - index -53 conjugated, lower primary times ident
`timescale 1ns/1ps
`default_nettype none
`include "scaler_params.svh"
module hybrid_subcarrier_scaler (
  input  wire logic                     i_mclk,                       // 100 MHz clock
  input  wire logic                     i_reset_n,                    // sync reset, low
  input  wire logic                     i_valid,                      // input word valid
  output logic                          o_ready,                      // input can be taken
  input  wire logic                     i_sym_start,                  // first word of symbol
  input  wire logic signed [`IDX_W-1:0] i_index,                      // subcarrier index
  input  wire logic signed [`SMP_W-1:0] i_re,                         // real part
  input  wire logic signed [`SMP_W-1:0] i_im,                         // imag part
  output logic                          o_valid,                      // output word valid
  input  wire logic                     i_ready,                      // downstream takes
  output logic                          o_sym_start,                  // first word of symbol
  output logic signed [`IDX_W-1:0]      o_index,                      // subcarrier index
  output logic signed [`SMP_W-1:0]      o_re,                         // scaled real
  output logic signed [`SMP_W-1:0]      o_im,                         // scaled imag
  input  wire logic                     i_power_level_select,         // power level bit
  input  wire logic                     i_reduced_bandwidth_select,   // reduced bandwidth
  input  wire logic [1:0]               i_outer_ident_select,         // outer ident a/b/c
  input  wire logic [`GAIN_W-1:0]       i_upper_primary_gain,         // upper primary
  input  wire logic [`GAIN_W-1:0]       i_lower_primary_gain,         // lower primary
  input  wire logic [`GAIN_W-1:0]       i_secondary_gain_a,           // secondary, level 0
  input  wire logic [`GAIN_W-1:0]       i_secondary_gain_b,           // secondary, level 1
  input  wire logic [`GAIN_W-1:0]       i_reference_gain,             // reference
  input  wire logic [`GAIN_W-1:0]       i_inner_ident_gain_a,         // inner ident, level 0
  input  wire logic [`GAIN_W-1:0]       i_inner_ident_gain_b,         // inner ident, level 1
  input  wire logic [`GAIN_W-1:0]       i_outer_ident_gain_a,         // outer ident a
  input  wire logic [`GAIN_W-1:0]       i_outer_ident_gain_b,         // outer ident b
  input  wire logic [`GAIN_W-1:0]       i_outer_ident_gain_c,         // outer ident c
  input  wire logic                     i_tab_wr,                     // tertiary table write
  input  wire logic                     i_tab_sel,                    // 0 table a, 1 table b
  input  wire logic [`TAB_AW-1:0]       i_tab_addr,                   // entry 0..24
  input  wire logic [`GAIN_W-1:0]       i_tab_data,                   // entry value
  output logic                          o_power_level_active,         // latched level
  output logic                          o_reduced_bandwidth_active    // latched bandwidth
);
  logic [`GAIN_W-1:0]      tertiary_gain_table_a [0:`TAB_DEPTH-1];
  logic [`GAIN_W-1:0]      tertiary_gain_table_b [0:`TAB_DEPTH-1];
  logic [`FIFO_W-1:0]      f_data;
  logic                    f_valid;
  logic                    f_sym;
  logic signed [`IDX_W-1:0] f_idx;
  logic signed [`SMP_W-1:0] f_re;
  logic signed [`SMP_W-1:0] f_im;
  logic                    adv;
  logic                    take_sym;
  logic                    cur_pl;
  logic                    cur_rbw;
  logic [1:0]              cur_oid;
  logic [1:0]              oid_active;
  logic [`IDX_W-1:0]       mag;
  logic [`TAB_AW-1:0]      tab_idx;
  logic [`GAIN_W-1:0]      oid_gain;
  logic [2*`GAIN_W-1:0]    oid_prod;
  logic [`GAIN_W-1:0]      next_gain;
  logic                    next_conj;
  logic                    next_zero;
  scaler_pkg::sideband_t   next_band;
  logic                    s1_valid;
  logic                    s1_sym;
  logic                    s1_load;
  logic signed [`IDX_W-1:0] s1_idx;
  logic signed [`SMP_W-1:0] s1_re;
  logic signed [`SMP_W-1:0] s1_im;
  logic [`GAIN_W-1:0]      s1_gain;
  logic                    s1_conj;
  logic                    s1_zero;
  scaler_pkg::sideband_t   s1_band;
  logic signed [`SMP_W-1:0] m_re;
  logic signed [`SMP_W-1:0] m_im;

  // ==========================================================
  // input buffer: absorbs downstream stalls, ready goes upstream
  sample_fifo #(
    .WIDTH (`FIFO_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .i_mclk     (i_mclk),
    .i_reset_n  (i_reset_n),
    .i_wr_valid (i_valid),
    .o_wr_ready (o_ready),
    .i_wr_data  ({i_sym_start, i_index, i_re, i_im}),
    .o_rd_valid (f_valid),
    .i_rd_ready (adv),
    .o_rd_data  (f_data)
  );

  // fifo word fields
  assign f_sym = f_data[`FIFO_W-1];
  assign f_idx = f_data[2*`SMP_W +: `IDX_W];
  assign f_re  = f_data[`SMP_W +: `SMP_W];
  assign f_im  = f_data[0 +: `SMP_W];

  // whole pipe moves together; stalls only when output is held
  assign adv = !o_valid || i_ready;

  // ==========================================================
  // symbol-boundary control latch
  // the first word of a symbol already sees the new settings
  assign take_sym = adv && f_valid && f_sym;
  assign cur_pl   = take_sym ? i_power_level_select : o_power_level_active;
  assign cur_rbw  = take_sym ? i_reduced_bandwidth_select : o_reduced_bandwidth_active;
  assign cur_oid  = take_sym ? i_outer_ident_select : oid_active;

  // settings change mid-symbol are ignored until the next start
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      o_power_level_active       <= 1'b0;
      o_reduced_bandwidth_active <= 1'b0;
      oid_active                 <= `OID_A;
    end
    else if (take_sym)
    begin
      o_power_level_active       <= i_power_level_select;
      o_reduced_bandwidth_active <= i_reduced_bandwidth_select;
      oid_active                 <= i_outer_ident_select;
    end
  end

  // ==========================================================
  // tertiary scale tables, loaded by configuration at any time
  always_ff @(posedge i_mclk)
  begin
    if (i_tab_wr && i_tab_addr < `TAB_AW'(`TAB_DEPTH))
    begin
      if (i_tab_sel)
        tertiary_gain_table_b[i_tab_addr] <= i_tab_data;
      else
        tertiary_gain_table_a[i_tab_addr] <= i_tab_data;
    end
  end

  // ==========================================================
  // outer ident gain: primary of that side times selected factor
  always_comb
  begin
    case (cur_oid)
      `OID_A:  oid_gain = i_outer_ident_gain_a;
      `OID_B:  oid_gain = i_outer_ident_gain_b;
      default: oid_gain = i_outer_ident_gain_c;
    endcase
    oid_prod = (f_idx[`IDX_W-1] ? i_lower_primary_gain : i_upper_primary_gain)
             * oid_gain;
  end

  // ==========================================================
  // sideband classification by index magnitude
  // index 0 is the analog carrier position, never scaled here
  always_comb
  begin
    mag       = f_idx[`IDX_W-1] ? `IDX_W'(-f_idx) : f_idx;
    tab_idx   = `TAB_AW'(mag - `TER_LO);
    next_band = scaler_pkg::SB_OFF;
    next_gain = '0;
    if (mag == '0 || mag > `MAX_IDX)
      next_band = scaler_pkg::SB_OFF;
    else if (mag == `REF_IDX)
    begin
      next_band = scaler_pkg::SB_REF;
      next_gain = i_reference_gain;
    end
    else if (mag <= `TER_HI)
    begin
      next_band = scaler_pkg::SB_TER;
      next_gain = cur_pl ? tertiary_gain_table_b[tab_idx]
                         : tertiary_gain_table_a[tab_idx];
    end
    else if (mag == `INNER_IDX)
    begin
      next_band = scaler_pkg::SB_INNER;
      next_gain = cur_pl ? i_inner_ident_gain_b : i_inner_ident_gain_a;
    end
    else if (mag <= `SEC_HI)
    begin
      next_band = scaler_pkg::SB_SEC;
      next_gain = cur_pl ? i_secondary_gain_b : i_secondary_gain_a;
    end
    else if (mag == `OUTER_IDX)
    begin
      next_band = scaler_pkg::SB_OUTER;
      if (|oid_prod[2*`GAIN_W-1 -: (`GAIN_W-`GAIN_FRAC)])
        next_gain = '1; // saturate a product above range
      else
        next_gain = oid_prod[`GAIN_FRAC +: `GAIN_W];
    end
    else if (mag >= `PRI_LO)
    begin
      next_band = scaler_pkg::SB_PRI;
      next_gain = f_idx[`IDX_W-1] ? i_lower_primary_gain : i_upper_primary_gain;
    end
    else
      next_band = scaler_pkg::SB_OFF;
    next_conj = f_idx[`IDX_W-1] && (mag == `INNER_IDX || mag == `OUTER_IDX);
    next_zero = (next_band == scaler_pkg::SB_OFF)
             || (cur_rbw && (next_band == scaler_pkg::SB_SEC
                          || next_band == scaler_pkg::SB_TER
                          || next_band == scaler_pkg::SB_INNER));
  end

  // ==========================================================
  // stage 1: classified word with its gain
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      s1_valid <= 1'b0;
      s1_sym   <= 1'b0;
      s1_load  <= 1'b0;
      s1_idx   <= '0;
      s1_re    <= '0;
      s1_im    <= '0;
      s1_gain  <= '0;
      s1_conj  <= 1'b0;
      s1_zero  <= 1'b1;
      s1_band  <= scaler_pkg::SB_OFF;
    end
    else
    begin
      s1_load <= adv;
      if (adv)
      begin
        s1_valid <= f_valid;
        s1_sym   <= f_sym;
        s1_idx   <= f_idx;
        s1_re    <= f_re;
        s1_im    <= f_im;
        s1_gain  <= next_gain;
        s1_conj  <= next_conj;
        s1_zero  <= next_zero;
        s1_band  <= next_band;
      end
    end
  end

  // stage 2 arithmetic
  subcarrier_multiplier u_mult (
    .i_re   (s1_re),
    .i_im   (s1_im),
    .i_gain (s1_gain),
    .i_conj (s1_conj),
    .i_zero (s1_zero),
    .o_re   (m_re),
    .o_im   (m_im)
  );

  // output register; the index is carried so frequency stays known
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      o_valid     <= 1'b0;
      o_sym_start <= 1'b0;
      o_index     <= '0;
      o_re        <= '0;
      o_im        <= '0;
    end
    else if (adv)
    begin
      o_valid     <= s1_valid;
      o_sym_start <= s1_sym;
      o_index     <= s1_idx;
      o_re        <= m_re;
      o_im        <= m_im;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  gap_blank_a: assert property (
    o_valid && (o_index >= $signed(`GAP_LO) && o_index <= $signed(`GAP_HI)
             || o_index <= -$signed(`GAP_LO) && o_index >= -$signed(`GAP_HI))
    |-> o_re == '0 && o_im == '0) else $error("gap subcarrier not blanked");
  range_blank_a: assert property (
    o_valid && (o_index > $signed(`MAX_IDX) || o_index < -$signed(`MAX_IDX)
             || o_index == '0) |-> o_re == '0 && o_im == '0)
    else $error("out of range index not blanked");
  index_pass_a: assert property (
    adv && s1_valid |=> o_valid && o_index == $past(s1_idx))
    else $error("index not carried to output");
  upper_primary_a: assert property (
    s1_valid && s1_load && s1_band == scaler_pkg::SB_PRI && !s1_idx[`IDX_W-1]
    |-> s1_gain == $past(i_upper_primary_gain)) else $error("upper primary gain wrong");
  lower_primary_a: assert property (
    s1_valid && s1_load && s1_band == scaler_pkg::SB_PRI && s1_idx[`IDX_W-1]
    |-> s1_gain == $past(i_lower_primary_gain)) else $error("lower primary gain wrong");
  secondary_pick_a: assert property (
    s1_valid && s1_load && s1_band == scaler_pkg::SB_SEC
    |-> s1_gain == (o_power_level_active ? $past(i_secondary_gain_b)
                                         : $past(i_secondary_gain_a)))
    else $error("secondary gain not chosen by power level");
  reduced_bw_a: assert property (
    s1_valid && o_reduced_bandwidth_active && (s1_band == scaler_pkg::SB_SEC
      || s1_band == scaler_pkg::SB_TER || s1_band == scaler_pkg::SB_INNER)
    |-> s1_zero ##1 (o_re == '0 && o_im == '0 || !$past(adv)))
    else $error("reduced bandwidth sideband not blanked");
  reference_gain_a: assert property (
    s1_valid && s1_load && s1_band == scaler_pkg::SB_REF && !s1_zero
    |-> s1_gain == $past(i_reference_gain)) else $error("reference gain wrong");
  ident_conj_a: assert property (
    s1_valid && (s1_idx == -$signed(`INNER_IDX) || s1_idx == -$signed(`OUTER_IDX))
    |-> s1_conj) else $error("mirrored ident not conjugated");
  no_conj_a: assert property (
    s1_valid && s1_band != scaler_pkg::SB_INNER && s1_band != scaler_pkg::SB_OUTER
    |-> !s1_conj) else $error("unexpected conjugation");
  ctrl_hold_a: assert property (
    !take_sym |=> $stable(o_power_level_active) && $stable(o_reduced_bandwidth_active))
    else $error("control changed inside a symbol");

  // stage 1 decisions, checked before the multiplier can hide them; last, output hold on stall
  inner_pick_a: assert property (
    s1_valid && s1_load && s1_band == scaler_pkg::SB_INNER
    |-> s1_gain == (o_power_level_active ? $past(i_inner_ident_gain_b)
                                         : $past(i_inner_ident_gain_a)))
    else $error("inner ident gain not chosen by power level");
  gap_zero_a: assert property (
    s1_valid && s1_band == scaler_pkg::SB_OFF |-> s1_zero)
    else $error("unused position not marked for blanking");
  primary_live_a: assert property (
    s1_valid && s1_band == scaler_pkg::SB_PRI |-> !s1_zero)
    else $error("primary subcarrier blanked");
  ref_live_a: assert property (
    s1_valid && s1_band == scaler_pkg::SB_REF |-> !s1_zero && !s1_conj)
    else $error("reference subcarrier blanked or conjugated");
  full_bw_live_a: assert property (
    s1_valid && !o_reduced_bandwidth_active && s1_band == scaler_pkg::SB_SEC
    |-> !s1_zero)
    else $error("secondary blanked at full bandwidth");
  out_hold_a: assert property (
    o_valid && !i_ready |=> o_valid && $stable(o_index) && $stable(o_re) && $stable(o_im))
    else $error("output changed while stalled");
endmodule : hybrid_subcarrier_scaler
`default_nettype wire

//--- testbench/ofdm_sink.sv
// downstream model: the symbol generator taking scaled subcarriers
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module ofdm_sink (
  input  wire logic i_mclk,    // clock
  input  wire logic i_reset_n, // sync reset, low
  input  wire logic i_slow,    // 1 stalls three of four cycles
  input  wire logic i_valid,   // word offered
  output logic      o_ready    // word taken
);
  logic [1:0] cnt;
  // =======================================
  // ready pattern; slow mode backs the pipe up into the fifo
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      cnt     <= 2'h0;
      o_ready <= 1'b0;
    end
    else
    begin
      cnt     <= cnt + {1'b0, i_valid};
      o_ready <= !i_slow || cnt == 2'h3;
    end
  end
endmodule : ofdm_sink
`default_nettype wire

//--- testbench/hybrid_subcarrier_scaler_tb.sv
// bench: full index sweeps for every control setting, checked word by word
// assumes the design files and the sink model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "scaler_params.svh"
module hybrid_subcarrier_scaler_tb;
  logic               clk, rst_n, vin, rdy_in, ss, pl, rbw, slow, cp, cr;
  logic               o_rdy, o_val, o_ss, pl_act, rbw_act, tw, tsel;
  logic [1:0]         os, co;
  logic signed [7:0]  idx, o_idx;
  logic signed [15:0] re, im, o_re, o_im;
  logic [4:0]         taddr;
  logic [15:0]        tdata;
  logic [15:0]        g [10];
  logic [42:0]        ev;
  logic [42:0]        expq [$];
  int                 fail_count, num_checks, s, k;
  hybrid_subcarrier_scaler uut (.i_mclk(clk), .i_reset_n(rst_n), .i_valid(vin),
    .o_ready(o_rdy), .i_sym_start(ss), .i_index(idx), .i_re(re), .i_im(im),
    .o_valid(o_val), .i_ready(rdy_in), .o_sym_start(o_ss), .o_index(o_idx),
    .o_re(o_re), .o_im(o_im), .i_power_level_select(pl),
    .i_reduced_bandwidth_select(rbw), .i_outer_ident_select(os),
    .i_upper_primary_gain(g[0]), .i_lower_primary_gain(g[1]),
    .i_secondary_gain_a(g[2]), .i_secondary_gain_b(g[3]), .i_reference_gain(g[4]),
    .i_inner_ident_gain_a(g[5]), .i_inner_ident_gain_b(g[6]),
    .i_outer_ident_gain_a(g[7]), .i_outer_ident_gain_b(g[8]),
    .i_outer_ident_gain_c(g[9]), .i_tab_wr(tw), .i_tab_sel(tsel),
    .i_tab_addr(taddr), .i_tab_data(tdata), .o_power_level_active(pl_act),
    .o_reduced_bandwidth_active(rbw_act));
  ofdm_sink sink (.i_mclk(clk), .i_reset_n(rst_n), .i_slow(slow), .i_valid(o_val),
    .o_ready(rdy_in));
  // =======================================
  // reference arithmetic; imag inputs are powers of two so conjugation is exact
  function automatic logic [15:0] mul(int x, int gn);
    longint p;
    p = (longint'(x) * gn) >>> 15;
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    return p[15:0];
  endfunction : mul
  function automatic int imv(int i);
    return (i % 2 != 0) ? 4096 : -2048;
  endfunction : imv
  function automatic logic [31:0] expv(int i);
    int a, gn;
    a = i < 0 ? -i : i;
    gn = 0;
    if (a == 1) gn = g[4];
    else if (a >= 2 && a <= 26) gn = cr ? 0 : cp ? 'h7E00 - (a-2)*'h200 : 'h800 + (a-2)*'h200;
    else if (a == 27) gn = cr ? 0 : cp ? g[6] : g[5];
    else if (a >= 28 && a <= 52) gn = cr ? 0 : cp ? g[3] : g[2];
    else if (a == 53) gn = mul(i > 0 ? g[0] : g[1], co == 0 ? g[7] : co == 1 ? g[8] : g[9]);
    else if (a >= 57) gn = i > 0 ? g[0] : g[1];
    if (i == -27 || i == -53) return {mul(i*64, gn), -mul(imv(i), gn)};
    return {mul(i*64, gn), mul(imv(i), gn)};
  endfunction : expv
  // =======================================
  task automatic chk_word(logic [40:0] got, logic [40:0] exp);
    num_checks++;
    if (got !== exp) fail_count++;
    if (got !== exp) $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
  endtask : chk_word
  task automatic chk_bit(logic [1:0] got, logic [1:0] exp);
    num_checks++;
    if (got !== exp) fail_count++;
    if (got !== exp) $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
  endtask : chk_bit
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // offer one word and hold it until the edge that takes it
  task automatic send(int i, logic first);
    idx = 8'(i);
    re = 16'(i*64);
    im = 16'(imv(i));
    ss = first;
    vin = 1'b1;
    while (o_rdy !== 1'b1) @(negedge clk);
    @(posedge clk);
    expq.push_back({first, 8'(i), expv(i), cp, cr});
    @(negedge clk);
  endtask : send
  // gains are not latched per symbol, so the pipe empties before they move
  task automatic drain;
    vin = 1'b0;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (expq.size() != 0 && k < 5000);
    if (expq.size() != 0) fail_count++;
  endtask : drain
  // =======================================
  // output monitor: every word taken by the sink is compared in order;
  // sampled at the falling edge, where the handshake for the next rise is settled
  always @(negedge clk)
  begin
    if (o_val === 1'b1 && rdy_in === 1'b1)
    begin
      ev = expq.size() != 0 ? expq.pop_front() : 'x;
      chk_word({o_ss, o_idx, o_re, o_im}, ev[42:2]);
      if (ev[42] === 1'b1) chk_bit({pl_act, rbw_act}, ev[1:0]);
    end
  end
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog: sweeps need about 6700 cycles at worst
  initial
  begin
    #600000;
    fail_count++;
    end_of_test();
  end
  initial
  begin
    {rst_n, vin, ss, pl, rbw, os, slow, tw, tsel, taddr, tdata} = '0;
    {idx, re, im, cp, cr, co} = '0;
    fail_count = 0;
    num_checks = 0;
    for (k = 0; k < 10; k++) g[k] = 16'h0400;
    repeat (16) @(negedge clk);
    chk_bit({o_rdy, o_val}, 2'h0);
    rst_n = 1'b1;
    // load both tertiary tables, entry k for index +/-(k+2)
    for (k = 0; k < 50; k++)
    begin
      tw = 1'b1;
      tsel = k >= 25;
      taddr = 5'(k % 25);
      tdata = tsel ? 16'(16'h7E00 - (k % 25)*16'h0200) : 16'(16'h0800 + k*16'h0200);
      @(negedge clk);
    end
    tw = 1'b0;
    for (s = 0; s < 16; s++)
    begin
      for (k = 0; k < 10; k++) g[k] = k < 7 ? 16'(1024*(k+1) + 512*s) : 16'(4096*(k-6+s%2));
      {cp, cr, co} = {s[0], s[1], s[3:2]};
      {pl, rbw, os} = {cp, cr, co};
      slow = s[0] ^ s[2];
      for (int i = -81; i <= 81; i++)
      begin
        if (i == 0) {pl, rbw, os} = {!cp, !cr, ~co};
        send(i, i == -81);
      end
      drain();
    end
    end_of_test();
  end
endmodule : hybrid_subcarrier_scaler_tb
`default_nettype wire
